// ==== hw/mrbr_pkg.sv ====
// constants for the matrix rotate and bit reverse block
// How it works
// - sixteen write-only input words and sixteen read-only output words share addresses
// - rotate mode: output word j bit i is input word i bit j
// - rotate mode: input word i bit 0 lands at output word 0 bit i
// - rotate disabled: output word j equals stored input word j
// - reverse off: written word stored with bit positions unchanged
// - reverse on: written bit k stored at bit 15 minus k
package mrbr_pkg;
    localparam int WORD_W = 16;
    localparam int NUM_WORDS = 16;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] MATRIX_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] MATRIX_LAST = 12'h03C;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h040;
    localparam int ROT_DIS_BIT = 0;
    localparam int WR_REV_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
endpackage

// ==== hw/mrbr_top.sv ====
// apb slave holding the 16x16 bit matrix with rotate and reverse
//
// The address map and the APB register port were decided locally.
`timescale 1ns/10ps
module mrbr_top #(
    parameter int WORD_W = mrbr_pkg::WORD_W,
    parameter int NUM_WORDS = mrbr_pkg::NUM_WORDS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [mrbr_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    logic [WORD_W-1:0] matrix_input_word [NUM_WORDS];
    logic [WORD_W-1:0] next_matrix_input_word [NUM_WORDS];
    logic [1:0] transform_control;
    logic [1:0] next_transform_control;
    logic [31:0] next_prdata;
    logic [WORD_W-1:0] read_view;
    logic access;
    logic setup;
    logic in_matrix;
    logic in_ctrl;
    logic [3:0] word_idx;

    function automatic logic [WORD_W-1:0] mrbr_reverse(input logic [WORD_W-1:0] w);
        logic [WORD_W-1:0] r;
        r = '0;
        for (int k = 0; k < WORD_W; k++) begin
            r[WORD_W-1-k] = w[k];
        end
        return r;
    endfunction

    assign pready = 1'b1;
    assign access = psel && penable && clk_en;
    // setup cycle: read data is prepared here so it stands from a flop in access
    assign setup = psel && !penable && clk_en;
    assign in_matrix = (paddr[1:0] == 2'h0) && (paddr <= mrbr_pkg::MATRIX_LAST);
    assign in_ctrl = (paddr == mrbr_pkg::CTRL_OFFSET);
    assign word_idx = paddr[5:2];

    always_comb begin
        next_transform_control = transform_control;
        for (int i = 0; i < NUM_WORDS; i++) begin
            next_matrix_input_word[i] = matrix_input_word[i];
        end
        if (access && pwrite && in_ctrl && pstrb[0]) begin
            next_transform_control = pwdata[1:0];
        end
        if (access && pwrite && in_matrix) begin
            if (transform_control[mrbr_pkg::WR_REV_BIT]) begin
                next_matrix_input_word[word_idx] = mrbr_reverse(pwdata[WORD_W-1:0]);
            end else begin
                next_matrix_input_word[word_idx] = pwdata[WORD_W-1:0];
            end
        end
    end

    // view of the addressed word: stored word when rotate is disabled, else bit word_idx of every stored word
    always_comb begin
        read_view = '0;
        for (int i = 0; i < NUM_WORDS; i++) begin
            if (transform_control[mrbr_pkg::ROT_DIS_BIT]) begin
                read_view[i] = matrix_input_word[word_idx][i];
            end else begin
                read_view[i] = matrix_input_word[i][word_idx];
            end
        end
    end

    // loaded at the setup edge, cleared at the access edge
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (setup && !pwrite) begin
            if (in_matrix) begin
                next_prdata[WORD_W-1:0] = read_view;
            end else if (in_ctrl) begin
                next_prdata[1:0] = transform_control;
            end
        end
    end

    // no write or state change happens between setup and access edges,
    // so the word prepared in setup still matches the stored matrix
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (clk_en) begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transform_control <= mrbr_pkg::CTRL_RESET;
            for (int i = 0; i < NUM_WORDS; i++) begin
                matrix_input_word[i] <= mrbr_pkg::WORD_RESET;
            end
        end else if (clk_en) begin
            transform_control <= next_transform_control;
            for (int i = 0; i < NUM_WORDS; i++) begin
                matrix_input_word[i] <= next_matrix_input_word[i];
            end
        end
    end

    // unmapped access flagged in the access cycle itself
    assign pslverr = access && !in_matrix && !in_ctrl;

    chk_rotate_read: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && in_matrix && !transform_control[0])
        |-> prdata[0] == matrix_input_word[0][word_idx])
        else $error("rotated read bit 0 wrong");
    chk_plain_read: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && in_matrix && transform_control[0])
        |-> prdata[15:0] == matrix_input_word[word_idx])
        else $error("unrotated read wrong");
    chk_word0_corner: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && in_matrix && !transform_control[0] && word_idx == 4'h0)
        |-> prdata[15] == matrix_input_word[15][0])
        else $error("word 0 bit 15 wrong");
    chk_plain_write: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && in_matrix && !transform_control[1])
        |=> matrix_input_word[$past(word_idx)] == $past(pwdata[15:0]))
        else $error("plain write not stored");
    chk_reverse_write: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && in_matrix && transform_control[1])
        |=> matrix_input_word[$past(word_idx)][15] == $past(pwdata[0]))
        else $error("reversed write bit wrong");
    chk_freeze_state: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(transform_control))
        else $error("control changed while frozen");
    chk_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && in_matrix) |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    chk_bad_addr: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !in_matrix && !in_ctrl) |-> pslverr)
        else $error("unmapped access not flagged");
    chk_full_reverse: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && in_matrix && transform_control[1])
        |=> matrix_input_word[$past(word_idx)] == mrbr_reverse($past(pwdata[15:0])))
        else $error("reversed write word wrong");
    chk_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && in_ctrl && pstrb[0])
        |=> transform_control == $past(pwdata[1:0]))
        else $error("control write not stored");
    chk_words_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(matrix_input_word[0]) && $stable(matrix_input_word[15]))
        else $error("words changed while frozen");
    chk_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
        psel |-> pready)
        else $error("ready not high");
    chk_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && $past(clk_en) && !(psel && penable)) |-> prdata == 32'h0000_0000)
        else $error("read data outside access");
    chk_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && in_ctrl) |-> prdata[1:0] == transform_control)
        else $error("control read wrong");
    cov_rot_read: cover property (@(posedge pclk) access && !pwrite && in_matrix && !transform_control[0]);
    cov_plain_read: cover property (@(posedge pclk) access && !pwrite && in_matrix && transform_control[0]);
    cov_rev_write: cover property (@(posedge pclk) access && pwrite && in_matrix && transform_control[1]);
    cov_ctrl_write: cover property (@(posedge pclk) access && pwrite && in_ctrl);
    cov_frozen_req: cover property (@(posedge pclk) psel && penable && !clk_en);
endmodule // mrbr_top

// ==== verif/mrbr_top_tb.sv ====
// self-checking bench for the matrix rotate and bit reverse block
`timescale 1ns/10ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin failures++; \
    $display("mismatch %s expected %h seen %h", n, e, s); end end
module mrbr_top_tb;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata;
    logic [3:0] pstrb = 4'hF;
    logic [32:0] exp_q[$], e;
    logic [15:0] m[16], v;
    int failures = 0, total_checks = 0, seed = 95139;
    always #5 pclk = ~pclk;
    mrbr_top mrbr_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // whole aligned word per access
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] x);
        exp_q.push_back(x);
        xfer(1'b0, a, 32'h00000000);
    endtask
    task automatic load(input logic [1:0] c);
        xfer(1'b1, 12'h040, {30'h00000000, c});
        for (int i = 0; i < 16; i++) begin
            m[i] = 16'($random(seed));
            xfer(1'b1, 12'(4 * i), {m[i], m[i]});
        end
    endtask
    // expected read view of the output words, rotated unless rot_off
    task automatic check(input logic rot_off, input logic rev);
        for (int j = 0; j < 16; j++) begin
            for (int i = 0; i < 16; i++) begin
                v[i] = rot_off ? m[j][rev ? 15 - i : i] : m[i][rev ? 15 - j : j];
            end
            rd(12'(4 * j), {17'h00000, v});
        end
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
            e = exp_q.pop_front();
            `CHK("read", e, {pslverr, prdata})
        end
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        report_and_stop;
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h040, 33'h000000000);
        rd(12'h000, 33'h000000000);
        for (int c = 0; c < 4; c++) begin
            load(2'(c));
            check(c[0], c[1]);
            rd(12'h040, {31'h00000000, 2'(c)});
            xfer(1'b1, 12'h040, {30'h00000000, c[1], ~c[0]});
            check(~c[0], c[1]);
            $display("test mode %0d done", c);
        end
        clk_en <= 1'b0;
        xfer(1'b1, 12'h040, 32'h00000001);
        clk_en <= 1'b1;
        rd(12'h040, 33'h000000002);
        $display("test freeze done");
        rd(12'h080, 33'h100000000);
        $display("test unmapped done");
        repeat (2) @(posedge pclk);
        report_and_stop;
    end
endmodule // mrbr_top_tb
